// ### hdl/dss_ctrl.sv
// Debug state sequencer with State1/State2 transition select registers
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "dss_defines.svh"

// Overview of operation
// - Three state control registers and match flags share one address.
// - View select 00/01/10/11 shows State1, State2, State3, match flags.
// - State1 register read at view 00; written at view 00 when disarmed.
// - State2 register read at view 01; written at view 01 when disarmed.
// - Code bits 3..0 pick the target state on a match in that state.
// - State1 codes 0..2: any match to State2, State3, Final.
// - State1 codes 3..5: only channel 2 acts, to State2, State3, Final.
// - State1 code 6: ch0 State2, ch1 State3; code 7: ch1 State3, ch0 Final.
// - State1 code 8: ch0 State2, ch2 State3; code 9: ch2 State3, ch0 Final.
// - State1 code a: ch1 State2, ch3 State3; code b: ch3 State3, ch1 Final.
// - State1 code c: channels 0..2 go to State2, channel 3 ignored.
// - Reserved codes cause no transition on any match.
// - Simultaneous non-Final matches: the lowest-numbered channel acts.
// - A match targeting Final State beats every other match.
// - State2 codes 0..2: any match to State1, State3, Final.
// - State2 codes 3..5: only channel 3 acts, to State1, State3, Final.
// - State2 code 6: ch0 State1, ch1 State3; code 7: ch1 State3, ch0 Final.
// - State2 code 8: ch0 State1, ch2 State3; code 9: ch2 State3, ch0 Final.
// - State2 code a: ch1 State1, ch3 State3; code b: ch3 State3, ch1 Final.
// - State2 code c: ch2 State1, ch3 Final; code d: ch0,1,3 Final.
module dss_ctrl
  import dss_pkg::*;
#(
  parameter int AW = 8,
  parameter int CH = 4
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [AW-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [CH-1:0] MATCH,
  output logic [7:0] RDATA,
  output logic ARMED,
  output logic [4:0] SEQ_STATE
);

  logic armed;
  logic [1:0] view;
  logic [3:0] code1;
  logic [3:0] code2;
  logic [3:0] code3;
  logic [CH-1:0] flags;
  dss_state_t state;
  dss_state_t next_state;
  dss_state_t tgt [CH];
  logic [CH-1:0] hit;
  logic [CH-1:0] fin_hit;
  logic ctrl_wr;
  logic shared_wr;
  logic arm_set;

  // State1 table; anything not listed leaves the channel inert
  function automatic dss_state_t tgt_s1(input logic [3:0] code,
                                         input logic [1:0] ch);
    dss_state_t r;
    r = DSS_IDLE;
    unique case (code)
      4'h0: r = DSS_ST2;
      4'h1: r = DSS_ST3;
      4'h2: r = DSS_FIN;
      4'h3: if (ch == 2'h2) r = DSS_ST2;
      4'h4: if (ch == 2'h2) r = DSS_ST3;
      4'h5: if (ch == 2'h2) r = DSS_FIN;
      4'h6: begin
        if (ch == 2'h0) r = DSS_ST2;
        if (ch == 2'h1) r = DSS_ST3;
      end
      4'h7: begin
        if (ch == 2'h1) r = DSS_ST3;
        if (ch == 2'h0) r = DSS_FIN;
      end
      4'h8: begin
        if (ch == 2'h0) r = DSS_ST2;
        if (ch == 2'h2) r = DSS_ST3;
      end
      4'h9: begin
        if (ch == 2'h2) r = DSS_ST3;
        if (ch == 2'h0) r = DSS_FIN;
      end
      4'ha: begin
        if (ch == 2'h1) r = DSS_ST2;
        if (ch == 2'h3) r = DSS_ST3;
      end
      4'hb: begin
        if (ch == 2'h3) r = DSS_ST3;
        if (ch == 2'h1) r = DSS_FIN;
      end
      4'hc: if (ch != 2'h3) r = DSS_ST2;
      default: r = DSS_IDLE;
    endcase
    return r;
  endfunction

  // State2 table
  function automatic dss_state_t tgt_s2(input logic [3:0] code,
                                         input logic [1:0] ch);
    dss_state_t r;
    r = DSS_IDLE;
    unique case (code)
      4'h0: r = DSS_ST1;
      4'h1: r = DSS_ST3;
      4'h2: r = DSS_FIN;
      4'h3: if (ch == 2'h3) r = DSS_ST1;
      4'h4: if (ch == 2'h3) r = DSS_ST3;
      4'h5: if (ch == 2'h3) r = DSS_FIN;
      4'h6: begin
        if (ch == 2'h0) r = DSS_ST1;
        if (ch == 2'h1) r = DSS_ST3;
      end
      4'h7: begin
        if (ch == 2'h1) r = DSS_ST3;
        if (ch == 2'h0) r = DSS_FIN;
      end
      4'h8: begin
        if (ch == 2'h0) r = DSS_ST1;
        if (ch == 2'h2) r = DSS_ST3;
      end
      4'h9: begin
        if (ch == 2'h2) r = DSS_ST3;
        if (ch == 2'h0) r = DSS_FIN;
      end
      4'ha: begin
        if (ch == 2'h1) r = DSS_ST1;
        if (ch == 2'h3) r = DSS_ST3;
      end
      4'hb: begin
        if (ch == 2'h3) r = DSS_ST3;
        if (ch == 2'h1) r = DSS_FIN;
      end
      4'hc: begin
        if (ch == 2'h2) r = DSS_ST1;
        if (ch == 2'h3) r = DSS_FIN;
      end
      4'hd: if (ch != 2'h2) r = DSS_FIN;
      default: r = DSS_IDLE;
    endcase
    return r;
  endfunction

  assign ctrl_wr = WR && (ADDR == `DSS_CTRL_OFS);
  assign arm_set = ctrl_wr && WDATA[`DSS_ARM_BIT];
  // Writes to the code registers are dropped while armed so a session is stable
  assign shared_wr = WR && (ADDR == `DSS_SHARED_OFS) && !armed;

  // Per-channel target for the current state
  for (genvar g = 0; g < CH; g++) begin : g_chan
    always_comb begin
      unique case (state)
        DSS_ST1: tgt[g] = tgt_s1(code1, 2'(g));
        DSS_ST2: tgt[g] = tgt_s2(code2, 2'(g));
        default: tgt[g] = DSS_IDLE;
      endcase
    end
    assign hit[g] = MATCH[g] && (tgt[g] != DSS_IDLE);
    assign fin_hit[g] = MATCH[g] && (tgt[g] == DSS_FIN);

    // Flags stick until the next arming; a match in the arming cycle sets only when already armed
    always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
        flags[g] <= 1'b0;
      end else if (armed && MATCH[g]) begin
        flags[g] <= 1'b1;
      end else if (arm_set) begin
        flags[g] <= 1'b0;
      end
    end
  end

  // Priority resolution among simultaneous matches
  always_comb begin
    next_state = DSS_IDLE;
    for (int i = CH - 1; i >= 0; i--) begin
      if (hit[i]) begin
        next_state = tgt[i];
      end
    end
    if (|fin_hit) begin
      next_state = DSS_FIN;
    end
  end

  // Arm bit and view select
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      armed <= 1'b0;
      view <= `DSS_VIEW_RST;
    end else if (ctrl_wr) begin
      armed <= WDATA[`DSS_ARM_BIT];
      view <= WDATA[`DSS_VIEW_MSB:`DSS_VIEW_LSB];
    end
  end

  // Transition select registers behind the shared address
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      code1 <= `DSS_CODE_RST;
      code2 <= `DSS_CODE_RST;
      code3 <= `DSS_CODE_RST;
    end else if (shared_wr) begin
      unique case (view)
        `DSS_VIEW_S1: code1 <= WDATA[`DSS_CODE_MSB:0];
        `DSS_VIEW_S2: code2 <= WDATA[`DSS_CODE_MSB:0];
        `DSS_VIEW_S3: code3 <= WDATA[`DSS_CODE_MSB:0];
        `DSS_VIEW_MF: code3 <= code3;
      endcase
    end
  end

  // Sequencer; State3 has no exits here, Final holds until the next control write
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= DSS_IDLE;
    end else if (arm_set) begin
      state <= DSS_ST1;
    end else if (!armed || ctrl_wr) begin
      state <= ctrl_wr ? DSS_IDLE : state;
    end else if (next_state != DSS_IDLE) begin
      state <= next_state;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 8'h00;
    end else if (!RD) begin
      RDATA <= 8'h00;
    end else if (ADDR == `DSS_CTRL_OFS) begin
      RDATA <= {armed, 5'h00, view};
    end else if (ADDR == `DSS_STAT_OFS) begin
      RDATA <= {3'h0, state};
    end else if (ADDR == `DSS_SHARED_OFS) begin
      unique case (view)
        `DSS_VIEW_S1: RDATA <= {4'h0, code1};
        `DSS_VIEW_S2: RDATA <= {4'h0, code2};
        `DSS_VIEW_S3: RDATA <= {4'h0, code3};
        `DSS_VIEW_MF: RDATA <= {{(8 - CH){1'b0}}, flags};
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  assign ARMED = armed;
  assign SEQ_STATE = state;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  logic run;
  assign run = armed && !ctrl_wr;

  s1_write_gate_a: assert property (
    WR && ADDR == `DSS_SHARED_OFS && view == `DSS_VIEW_S1 && !armed
    |=> code1 == $past(WDATA[3:0]) && $stable(code2))
    else $error("State1 select not written");

  s2_write_gate_a: assert property (
    WR && ADDR == `DSS_SHARED_OFS && view == `DSS_VIEW_S2 && !armed
    |=> code2 == $past(WDATA[3:0]) && $stable(code1))
    else $error("State2 select not written");

  armed_write_lock_a: assert property (
    WR && ADDR == `DSS_SHARED_OFS && armed
    |=> $stable(code1) && $stable(code2))
    else $error("Select written while armed");

  shared_read_view_a: assert property (
    RD && ADDR == `DSS_SHARED_OFS && view == `DSS_VIEW_S2
    |=> RDATA == {4'h0, $past(code2)} ##1 RDATA == 8'h00 || $past(RD))
    else $error("Shared read shows wrong register");

  flag_view_a: assert property (
    RD && ADDR == `DSS_SHARED_OFS && view == `DSS_VIEW_MF
    |=> RDATA[3:0] == $past(flags))
    else $error("Match flags not shown");

  s1_any_fin_a: assert property (
    state == DSS_ST1 && run && code1 == 4'h2 && |MATCH
    |=> state == DSS_FIN)
    else $error("Any match did not reach Final");

  low_chan_wins_a: assert property (
    state == DSS_ST1 && run && code1 == 4'h6 && MATCH[1:0] == 2'b11
    |=> state == DSS_ST2)
    else $error("Lower channel did not win");

  final_prio_a: assert property (
    state == DSS_ST2 && run && code2 == 4'h7 && MATCH[1:0] == 2'b11
    |=> state == DSS_FIN)
    else $error("Final State lost priority");

  reserved_hold_a: assert property (
    state == DSS_ST1 && run && code1 >= 4'hd
    |=> state == DSS_ST1)
    else $error("Reserved code moved sequencer");

  s2_ch3_only_a: assert property (
    state == DSS_ST2 && run && code2 == 4'h3 && !MATCH[3]
    |=> state == DSS_ST2)
    else $error("Ignored channel moved sequencer");

  s2_skip_ch2_a: assert property (
    state == DSS_ST2 && run && code2 == 4'hd && MATCH == 4'h4
    |=> state == DSS_ST2)
    else $error("Channel 2 acted under code d");

  disarm_idle_a: assert property (
    (!armed || ctrl_wr) && !arm_set |=> state == DSS_IDLE)
    else $error("Sequencer moved while disarmed");

  s1_any_s3_a: assert property (
    state == DSS_ST1 && run && code1 == 4'h1 && |MATCH
    |=> state == DSS_ST3)
    else $error("Any match did not reach State3");

  s1_ch2_only_a: assert property (
    state == DSS_ST1 && run && code1 == 4'h4 && !MATCH[2]
    |=> state == DSS_ST1)
    else $error("Channel other than 2 moved sequencer");

  s1_skip_ch3_a: assert property (
    state == DSS_ST1 && run && code1 == 4'hc && MATCH == 4'h8
    |=> state == DSS_ST1)
    else $error("Channel 3 acted under code c");

  s2_any_s1_a: assert property (
    state == DSS_ST2 && run && code2 == 4'h0 && |MATCH
    |=> state == DSS_ST1)
    else $error("Any match did not return to State1");

  idle_match_hold_a: assert property (
    run && MATCH == '0 |=> $stable(state))
    else $error("Sequencer moved without a match");

  s1_to_s2_c: cover property (state == DSS_ST1 ##1 state == DSS_ST2);
  s2_to_s1_c: cover property (state == DSS_ST2 ##1 state == DSS_ST1);
  reach_fin_c: cover property (state == DSS_ST2 ##1 state == DSS_FIN);
  s1_to_s3_c: cover property (state == DSS_ST1 ##1 state == DSS_ST3);
  tie_break_c: cover property (run && $countones(hit) > 1);

endmodule

// ### hdl/dss_defines.svh
// Offsets, field positions and reset values of the debug state sequencer
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH
`define DSS_CTRL_OFS 8'h20
`define DSS_STAT_OFS 8'h21
`define DSS_SHARED_OFS 8'h27
`define DSS_ARM_BIT 7
`define DSS_VIEW_MSB 1
`define DSS_VIEW_LSB 0
`define DSS_CODE_MSB 3
`define DSS_VIEW_S1 2'h0
`define DSS_VIEW_S2 2'h1
`define DSS_VIEW_S3 2'h2
`define DSS_VIEW_MF 2'h3
`define DSS_CODE_RST 4'h0
`define DSS_VIEW_RST 2'h0
`endif

// ### hdl/dss_pkg.sv
// Types of the debug state sequencer
package dss_pkg;
  typedef enum logic [4:0] {
    DSS_IDLE = 5'h01,
    DSS_ST1 = 5'h02,
    DSS_ST2 = 5'h04,
    DSS_ST3 = 5'h08,
    DSS_FIN = 5'h10
  } dss_state_t;
endpackage

// ### dv/dss_ctrl_tb_top.sv
// Self-checking testbench for the debug state sequencer control block
`timescale 1ns/1ps
module dss_ctrl_tb_top;
  import dss_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] match = 4'h0;
  logic [7:0] rdata;
  logic armed;
  logic [4:0] seq_state;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Target per channel, one nibble each: 1 State1, 2 State2, 3 State3, 4 Final, 0 inert
  localparam logic [15:0] TGT1 [16] = '{16'h2222, 16'h3333, 16'h4444, 16'h0200, 16'h0300,
    16'h0400, 16'h0032, 16'h0034, 16'h0302, 16'h0304, 16'h3020, 16'h3040, 16'h0222,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] TGT2 [16] = '{16'h1111, 16'h3333, 16'h4444, 16'h1000, 16'h3000,
    16'h4000, 16'h0031, 16'h0034, 16'h0301, 16'h0304, 16'h3010, 16'h3040, 16'h4100,
    16'h4044, 16'h0000, 16'h0000};
  localparam logic [7:0] VIEW_EXP [4] = '{8'h0b, 8'h0c, 8'h07, 8'h00};

  always #12.5 core_clk = ~core_clk;

  dss_ctrl #(.AW(8), .CH(4)) uut (
    .CORE_CLK(core_clk),
    .NRST(nrst),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .MATCH(match),
    .RDATA(rdata),
    .ARMED(armed),
    .SEQ_STATE(seq_state)
  );

  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs roughly 6300 cycles; the ceiling leaves ample slack
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk);
    match <= m;
    @(posedge core_clk);
    match <= 4'h0;
    #1;
  endtask

  function automatic logic [4:0] expect_next(input int st, input logic [3:0] c,
                                             input logic [3:0] m);
    logic [15:0] t;
    logic [2:0] sel;
    t = (st == 1) ? TGT1[c] : TGT2[c];
    sel = 3'h0;
    // Walk from the top so the lowest firing channel lands last, unless Final is taken
    for (int i = 3; i >= 0; i--) begin
      if (m[i] && t[4*i +: 3] != 3'h0 && sel != 3'h4) begin
        sel = t[4*i +: 3];
      end
    end
    case (sel)
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h08;
      3'h4: return 5'h10;
      default: return (st == 1) ? 5'h02 : 5'h04;
    endcase
  endfunction

  task automatic test_views();
    logic [7:0] d;
    for (int v = 0; v < 4; v++) begin
      bus_wr(8'h20, 8'(v));
      bus_wr(8'h27, (v == 3) ? 8'h0f : VIEW_EXP[v]);
    end
    for (int v = 0; v < 4; v++) begin
      bus_wr(8'h20, 8'(v));
      bus_rd(8'h27, d);
      check(d, VIEW_EXP[v]);
    end
    bus_wr(8'h30, 8'hff);
    bus_rd(8'h30, d);
    check(d, 8'h00);
  endtask

  task automatic test_refusals();
    logic [7:0] d;
    bus_wr(8'h20, 8'h80);
    check({7'h00, armed}, 8'h01);
    bus_wr(8'h27, 8'h05);
    bus_wr(8'h20, 8'h81);
    bus_wr(8'h27, 8'h03);
    bus_wr(8'h20, 8'h00);
    bus_rd(8'h27, d);
    check(d, 8'h0b);
    bus_wr(8'h20, 8'h01);
    bus_rd(8'h27, d);
    check(d, 8'h0c);
    pulse(4'hf);
    check({3'h0, seq_state}, 8'h01);
    bus_wr(8'h20, 8'h00);
    bus_wr(8'h27, 8'h0d);
    bus_wr(8'h20, 8'h80);
    pulse(4'h5);
    check({3'h0, seq_state}, 8'h02);
    bus_rd(8'h21, d);
    check(d, 8'h02);
    bus_rd(8'h20, d);
    check(d, 8'h80);
    bus_wr(8'h20, 8'h03);
    bus_rd(8'h27, d);
    check(d, 8'h05);
    bus_wr(8'h20, 8'h83);
    bus_rd(8'h27, d);
    check(d, 8'h00);
  endtask

  // Every code against every non-empty match set; State2 is entered through code 0 of State1
  task automatic run_transitions(input int st);
    for (int c = 0; c < 16; c++) begin
      for (int m = 1; m < 16; m++) begin
        bus_wr(8'h20, 8'h00);
        bus_wr(8'h27, (st == 1) ? 8'(c) : 8'h00);
        bus_wr(8'h20, 8'h01);
        bus_wr(8'h27, 8'(c));
        bus_wr(8'h20, 8'h80);
        if (st == 2) begin
          pulse(4'h1);
        end
        check({3'h0, seq_state}, (st == 1) ? 8'h02 : 8'h04);
        pulse(4'(m));
        check({3'h0, seq_state}, {3'h0, expect_next(st, 4'(c), 4'(m))});
      end
    end
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    check(rdata, 8'h00);
    check({7'h00, armed}, 8'h00);
    check({3'h0, seq_state}, 8'h01);
    test_views();
    test_refusals();
    run_transitions(1);
    run_transitions(2);
    give_verdict();
  end
endmodule
